// ===== logic/uif_pkg.sv
// Package of constants and carrier types for the uart interrupt and line format block
package uif_pkg;

	// Register word offsets (byte addresses on APB)
	localparam logic [4:0] OFS_DATA    = 5'h00;
	localparam logic [4:0] OFS_IEN     = 5'h04;
	localparam logic [4:0] OFS_IDENT   = 5'h08;
	localparam logic [4:0] OFS_LFC     = 5'h0c;
	localparam logic [4:0] OFS_MCTL    = 5'h10;
	localparam logic [4:0] OFS_LSTAT   = 5'h14;
	localparam logic [4:0] OFS_MSTAT   = 5'h18;
	localparam logic [4:0] OFS_SCRATCH = 5'h1c;

	// Field positions
	localparam int IEN_RXDATA  = 0;
	localparam int IEN_TXEMPTY = 1;
	localparam int IEN_LINE    = 2;
	localparam int IEN_MODEM   = 3;
	localparam int MC_OUT2     = 3;
	localparam int MC_LOOP     = 4;

	// Reset values
	localparam logic [7:0] IEN_RST  = 8'h00;
	localparam logic [7:0] LFC_RST  = 8'h00;
	localparam logic [7:0] MCTL_RST = 8'h00;
	localparam logic [7:0] DIV_RST  = 8'h01;

	// Ident codes
	localparam logic [2:0] ID_NONE    = 3'h1;
	localparam logic [2:0] ID_LINE    = 3'h6;
	localparam logic [2:0] ID_RXDATA  = 3'h4;
	localparam logic [2:0] ID_TXEMPTY = 3'h2;
	localparam logic [2:0] ID_MODEM   = 3'h0;

	// Serial timing: sixteen enable ticks per bit
	localparam logic [3:0] TICKS_LAST = 4'hf;
	localparam logic [3:0] TICKS_MID  = 4'h7;

	typedef enum logic [2:0] {TX_IDLE, TX_START, TX_DATA, TX_PAR, TX_STOP} uif_tx_t;
	typedef enum logic [2:0] {RX_IDLE, RX_START, RX_DATA, RX_PAR, RX_STOP} uif_rx_t;

	// Line format control fields
	typedef struct packed {
		logic       divisor_select_bit;
		logic       brk;
		logic       stick;
		logic       even;
		logic       par_en;
		logic       stop2;
		logic [1:0] wlen;
	} uif_lfc_t;

	// Modem input group
	typedef struct packed {
		logic cts;
		logic dsr;
		logic ri;
		logic dcd;
	} uif_modem_t;

	// Whole block state
	typedef struct packed {
		logic [7:0]  ien;
		uif_lfc_t    lfc;
		logic [7:0]  mctl;
		logic [7:0]  scratch;
		logic [15:0] divisor;
		logic [15:0] div_cnt;
		logic        tick;
		logic [7:0]  tx_holding_reg;
		logic        tx_holding_empty;
		uif_tx_t     tx_st;
		logic [7:0]  tx_shift;
		logic [2:0]  tx_bit;
		logic [3:0]  tx_tck;
		logic        tx_line;
		logic        tx_half;
		uif_rx_t     rx_st;
		logic [7:0]  rx_shift;
		logic [2:0]  rx_bit;
		logic [3:0]  rx_tck;
		logic        rx_par_acc;
		logic        rx_par_bad;
		logic [7:0]  rx_buffer_reg;
		logic        rx_ready;
		logic        overrun;
		logic        par_err;
		logic        frame_err;
		logic        brk_det;
		logic        brk_seen;
		logic        sin_s1;
		logic        sin_s2;
		uif_modem_t  mdm_s1;
		uif_modem_t  mdm_s2;
		logic [3:0]  mdm_delta;
		logic        tx_empty_irq;
		logic        ident_rd_pend;
		logic [31:0] prdata;
		logic        pready;
		logic        pslverr;
		logic        irq_output;
		logic        serial_output;
		logic        rts_n;
		logic        dtr_n;
	} uif_state_t;

endpackage : uif_pkg

// ===== logic/uif_core.sv
// Interrupt control, line format and serial framing of the async comm element
module uif_core (
	input  wire logic               pclk,          // 40 MHz bus clock
	input  wire logic               presetn,       // Async reset, active low
	input  wire logic               psel,          // APB select
	input  wire logic               penable,       // APB access phase
	input  wire logic               pwrite,        // APB write
	input  wire logic [4:0]         paddr,         // APB byte address
	input  wire logic [31:0]        pwdata,        // APB write data
	output logic      [31:0]        prdata,        // APB read data
	output logic                    pready,        // APB ready
	output logic                    pslverr,       // APB error, unmapped address
	input  wire logic               serial_input,  // Serial receive line
	input  wire uif_pkg::uif_modem_t modem_in_n,   // Modem inputs, active low
	output logic                    serial_output, // Serial transmit line
	output logic                    rts_n,         // Request to send, active low
	output logic                    dtr_n,         // Terminal ready, active low
	output logic                    irq_output     // Interrupt, active high
);

	uif_pkg::uif_state_t s_ff, nxt_s;

	// Data bits minus one for a given word length code
	function automatic logic [2:0] last_bit(input logic [1:0] wl);
		last_bit = {1'b1, wl};
	endfunction : last_bit

	// Parity bit to send or expect over the collected data
	function automatic logic par_bit(input uif_pkg::uif_lfc_t f, input logic xr);
		if (f.stick)
			par_bit = ~f.even;
		else
			par_bit = f.even ? xr : ~xr;
	endfunction : par_bit

	logic        acc;
	logic        rd;
	logic        wr;
	logic        known;
	logic [7:0]  rdat;
	logic [3:0]  pend;
	logic [2:0]  code;
	logic        rx_in;
	logic [3:0]  mdm_now;
	logic [3:0]  mdm_old;

	always_comb begin
		acc = psel & penable;
		rd = acc & ~pwrite;
		wr = acc & pwrite;
	end

	// Main next-state logic
	always_comb begin
		nxt_s = s_ff;
		nxt_s.tick = 1'b0;
		nxt_s.pready = 1'b0;
		nxt_s.pslverr = 1'b0;
		known = 1'b1;
		rdat = 8'h00;

		// Loopback routes the transmitter into the receiver
		rx_in = s_ff.mctl[uif_pkg::MC_LOOP] ? s_ff.tx_line : s_ff.sin_s2;
		if (s_ff.mctl[uif_pkg::MC_LOOP]) begin
			mdm_now = {s_ff.mctl[1], s_ff.mctl[0], s_ff.mctl[2], s_ff.mctl[3]};
		end else begin
			mdm_now = ~s_ff.mdm_s2;
		end
		mdm_old = ~s_ff.mdm_s1;
		nxt_s.sin_s1 = serial_input;
		nxt_s.sin_s2 = s_ff.sin_s1;
		nxt_s.mdm_s1 = modem_in_n;
		nxt_s.mdm_s2 = s_ff.mdm_s1;

		// Baud divider makes one tick per sixteenth of a bit
		if (s_ff.div_cnt == 16'h0000) begin
			nxt_s.div_cnt = s_ff.divisor - 16'h0001;
			nxt_s.tick = 1'b1;
		end else begin
			nxt_s.div_cnt = s_ff.div_cnt - 16'h0001;
		end

		// Transmitter; it keeps running during break
		if (s_ff.tick) begin
			case (s_ff.tx_st)
				uif_pkg::TX_IDLE: begin
					nxt_s.tx_line = 1'b1;
					if (!s_ff.tx_holding_empty) begin
						nxt_s.tx_shift = s_ff.tx_holding_reg;
						nxt_s.tx_holding_empty = 1'b1;
						nxt_s.tx_empty_irq = 1'b1;
						nxt_s.tx_st = uif_pkg::TX_START;
						nxt_s.tx_tck = 4'h0;
						nxt_s.tx_line = 1'b0;
					end
				end
				uif_pkg::TX_START: begin
					nxt_s.tx_tck = s_ff.tx_tck + 4'h1;
					if (s_ff.tx_tck == uif_pkg::TICKS_LAST) begin
						nxt_s.tx_st = uif_pkg::TX_DATA;
						nxt_s.tx_bit = 3'h0;
						nxt_s.tx_line = s_ff.tx_shift[0];
					end
				end
				uif_pkg::TX_DATA: begin
					nxt_s.tx_tck = s_ff.tx_tck + 4'h1;
					if (s_ff.tx_tck == uif_pkg::TICKS_LAST) begin
						if (s_ff.tx_bit == last_bit(s_ff.lfc.wlen)) begin
							if (s_ff.lfc.par_en) begin
								nxt_s.tx_st = uif_pkg::TX_PAR;
								nxt_s.tx_line = par_bit(s_ff.lfc, ^(s_ff.tx_shift &
									(8'hff >> (3'h7 - last_bit(s_ff.lfc.wlen)))));
							end else begin
								nxt_s.tx_st = uif_pkg::TX_STOP;
								nxt_s.tx_line = 1'b1;
							end
							nxt_s.tx_half = 1'b0;
						end else begin
							nxt_s.tx_bit = s_ff.tx_bit + 3'h1;
							nxt_s.tx_line = s_ff.tx_shift[s_ff.tx_bit + 3'h1];
						end
					end
				end
				uif_pkg::TX_PAR: begin
					nxt_s.tx_tck = s_ff.tx_tck + 4'h1;
					if (s_ff.tx_tck == uif_pkg::TICKS_LAST) begin
						nxt_s.tx_st = uif_pkg::TX_STOP;
						nxt_s.tx_line = 1'b1;
					end
				end
				uif_pkg::TX_STOP: begin
					nxt_s.tx_tck = s_ff.tx_tck + 4'h1;
					// Second stop is full, or half for five-bit words
					if (s_ff.tx_tck == uif_pkg::TICKS_LAST ||
						(s_ff.tx_half && s_ff.lfc.wlen == 2'b00 &&
						 s_ff.tx_tck == uif_pkg::TICKS_MID)) begin
						if (s_ff.lfc.stop2 && !s_ff.tx_half) begin
							nxt_s.tx_half = 1'b1;
							nxt_s.tx_tck = 4'h0;
						end else begin
							nxt_s.tx_st = uif_pkg::TX_IDLE;
						end
					end
				end
				default: nxt_s.tx_st = uif_pkg::TX_IDLE;
			endcase
		end

		// Ident read clears tx empty only if it was reported then
		if (s_ff.ident_rd_pend) begin
			nxt_s.ident_rd_pend = 1'b0;
		end

		// APB access; one wait state, answer on the second access cycle
		if (acc && !s_ff.pready) begin
			nxt_s.pready = 1'b1;
			case (paddr)
				uif_pkg::OFS_DATA: begin
					if (s_ff.lfc.divisor_select_bit) begin
						rdat = s_ff.divisor[7:0];
						if (wr) nxt_s.divisor[7:0] = pwdata[7:0];
					end else if (wr) begin
						nxt_s.tx_holding_reg = pwdata[7:0];
						nxt_s.tx_holding_empty = 1'b0;
						nxt_s.tx_empty_irq = 1'b0;
					end else begin
						rdat = s_ff.rx_buffer_reg;
						nxt_s.rx_ready = 1'b0;
					end
				end
				uif_pkg::OFS_IEN: begin
					if (s_ff.lfc.divisor_select_bit) begin
						rdat = s_ff.divisor[15:8];
						if (wr) nxt_s.divisor[15:8] = pwdata[7:0];
					end else begin
						rdat = {4'h0, s_ff.ien[3:0]};
						if (wr) nxt_s.ien = {4'h0, pwdata[3:0]};
					end
				end
				uif_pkg::OFS_IDENT: begin
					rdat = {5'h00, code};
					if (rd && code == uif_pkg::ID_TXEMPTY)
						nxt_s.tx_empty_irq = 1'b0;
				end
				uif_pkg::OFS_LFC: begin
					rdat = s_ff.lfc;
					if (wr) nxt_s.lfc = pwdata[7:0];
				end
				uif_pkg::OFS_MCTL: begin
					rdat = {3'h0, s_ff.mctl[4:0]};
					if (wr) nxt_s.mctl = {3'h0, pwdata[4:0]};
				end
				uif_pkg::OFS_LSTAT: begin
					rdat = {1'b0, s_ff.tx_holding_empty & (s_ff.tx_st == uif_pkg::TX_IDLE),
						s_ff.tx_holding_empty, s_ff.brk_det, s_ff.frame_err,
						s_ff.par_err, s_ff.overrun, s_ff.rx_ready};
					if (rd) begin
						nxt_s.overrun = 1'b0;
						nxt_s.par_err = 1'b0;
						nxt_s.frame_err = 1'b0;
						nxt_s.brk_det = 1'b0;
					end
				end
				uif_pkg::OFS_MSTAT: begin
					rdat = {mdm_now[0], mdm_now[1], mdm_now[2], mdm_now[3], s_ff.mdm_delta};
					if (rd) nxt_s.mdm_delta = 4'h0;
				end
				uif_pkg::OFS_SCRATCH: begin
					rdat = s_ff.scratch;
					if (wr) nxt_s.scratch = pwdata[7:0];
				end
				default: begin
					known = 1'b0;
					nxt_s.pslverr = 1'b1;
				end
			endcase
			if (!pwrite) nxt_s.prdata = {24'h000000, rdat};
			if (!known) nxt_s.prdata = 32'h00000000;
		end

		// Modem deltas after the bus access, so a new change beats a clearing read
		if (!s_ff.mctl[uif_pkg::MC_LOOP]) begin
			if (mdm_old[3] != mdm_now[3]) nxt_s.mdm_delta[0] = 1'b1;
			if (mdm_old[2] != mdm_now[2]) nxt_s.mdm_delta[1] = 1'b1;
			if (!mdm_old[1] && mdm_now[1]) nxt_s.mdm_delta[2] = 1'b1;
			if (mdm_old[0] != mdm_now[0]) nxt_s.mdm_delta[3] = 1'b1;
		end

		// Receiver after the bus access too: a finished character wins over a read
		if (s_ff.tick) begin
			case (s_ff.rx_st)
				uif_pkg::RX_IDLE: begin
					if (!rx_in) begin
						nxt_s.rx_st = uif_pkg::RX_START;
						nxt_s.rx_tck = 4'h0;
					end
				end
				uif_pkg::RX_START: begin
					nxt_s.rx_tck = s_ff.rx_tck + 4'h1;
					if (s_ff.rx_tck == uif_pkg::TICKS_MID) begin
						if (rx_in) begin
							nxt_s.rx_st = uif_pkg::RX_IDLE;   // Glitch, not a start bit
						end else begin
							nxt_s.rx_st = uif_pkg::RX_DATA;
							nxt_s.rx_tck = 4'h0;
							nxt_s.rx_bit = 3'h0;
							nxt_s.rx_shift = 8'h00;
							nxt_s.brk_seen = 1'b1;
						end
					end
				end
				uif_pkg::RX_DATA: begin
					nxt_s.rx_tck = s_ff.rx_tck + 4'h1;
					if (s_ff.rx_tck == uif_pkg::TICKS_LAST) begin
						nxt_s.rx_shift[s_ff.rx_bit] = rx_in;
						if (rx_in) nxt_s.brk_seen = 1'b0;
						if (s_ff.rx_bit == last_bit(s_ff.lfc.wlen)) begin
							nxt_s.rx_st = s_ff.lfc.par_en ? uif_pkg::RX_PAR : uif_pkg::RX_STOP;
							nxt_s.rx_par_bad = 1'b0;
						end
						nxt_s.rx_bit = s_ff.rx_bit + 3'h1;
					end
				end
				uif_pkg::RX_PAR: begin
					nxt_s.rx_tck = s_ff.rx_tck + 4'h1;
					if (s_ff.rx_tck == uif_pkg::TICKS_LAST) begin
						nxt_s.rx_par_bad = (rx_in != par_bit(s_ff.lfc, ^s_ff.rx_shift));
						if (rx_in) nxt_s.brk_seen = 1'b0;
						nxt_s.rx_st = uif_pkg::RX_STOP;
					end
				end
				uif_pkg::RX_STOP: begin
					nxt_s.rx_tck = s_ff.rx_tck + 4'h1;
					if (s_ff.rx_tck == uif_pkg::TICKS_LAST) begin
						nxt_s.rx_st = uif_pkg::RX_IDLE;
						// A buffer read in this same cycle is no overrun
						if (nxt_s.rx_ready) nxt_s.overrun = 1'b1;
						nxt_s.rx_buffer_reg = s_ff.rx_shift;
						nxt_s.rx_ready = 1'b1;
						if (s_ff.rx_par_bad) nxt_s.par_err = 1'b1;
						if (!rx_in) nxt_s.frame_err = 1'b1;
						if (!rx_in && s_ff.brk_seen) nxt_s.brk_det = 1'b1;
					end
				end
				default: nxt_s.rx_st = uif_pkg::RX_IDLE;
			endcase
		end

		// Outputs: break forces space, loopback forces mark even over break and idles modem pins
		nxt_s.serial_output = s_ff.mctl[uif_pkg::MC_LOOP] ? 1'b1 :
			(s_ff.lfc.brk ? 1'b0 : s_ff.tx_line);
		nxt_s.rts_n = s_ff.mctl[uif_pkg::MC_LOOP] | ~s_ff.mctl[1];
		nxt_s.dtr_n = s_ff.mctl[uif_pkg::MC_LOOP] | ~s_ff.mctl[0];
		// Gated by output-2, and held low in loopback whatever output-2 says
		nxt_s.irq_output = (code != uif_pkg::ID_NONE) &
			(s_ff.mctl[uif_pkg::MC_OUT2] & ~s_ff.mctl[uif_pkg::MC_LOOP]);
	end

	// Pending sources gated by enables, then prioritised
	always_comb begin
		pend[0] = s_ff.ien[uif_pkg::IEN_LINE] &
			(s_ff.overrun | s_ff.par_err | s_ff.frame_err | s_ff.brk_det);
		pend[1] = s_ff.ien[uif_pkg::IEN_RXDATA] & s_ff.rx_ready;
		pend[2] = s_ff.ien[uif_pkg::IEN_TXEMPTY] & s_ff.tx_empty_irq;
		pend[3] = s_ff.ien[uif_pkg::IEN_MODEM] & (|s_ff.mdm_delta);
		if (pend[0])
			code = uif_pkg::ID_LINE;
		else if (pend[1])
			code = uif_pkg::ID_RXDATA;
		else if (pend[2])
			code = uif_pkg::ID_TXEMPTY;
		else if (pend[3])
			code = uif_pkg::ID_MODEM;
		else
			code = uif_pkg::ID_NONE;
	end

	// State register
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			s_ff <= '0;
			s_ff.ien <= uif_pkg::IEN_RST;
			s_ff.lfc <= uif_pkg::LFC_RST;
			s_ff.mctl <= uif_pkg::MCTL_RST;
			s_ff.divisor <= {8'h00, uif_pkg::DIV_RST};
			s_ff.tx_holding_empty <= 1'b1;
			s_ff.tx_line <= 1'b1;
			s_ff.serial_output <= 1'b1;
			s_ff.rts_n <= 1'b1;
			s_ff.dtr_n <= 1'b1;
			s_ff.sin_s1 <= 1'b1;
			s_ff.sin_s2 <= 1'b1;
			s_ff.mdm_s1 <= 4'hf;
			s_ff.mdm_s2 <= 4'hf;
		end else begin
			s_ff <= nxt_s;
		end
	end

	// Ports from flip-flops
	always_comb begin
		prdata = s_ff.prdata;
		pready = s_ff.pready;
		pslverr = s_ff.pslverr;
		serial_output = s_ff.serial_output;
		rts_n = s_ff.rts_n;
		dtr_n = s_ff.dtr_n;
		irq_output = s_ff.irq_output;
	end

endmodule : uif_core

// ===== testbench/uif_checker_sva.sv
// Checker of interrupt, ident and line format behaviour at the core's ports
module uif_checker (
	input wire logic        pclk,          // Bus clock
	input wire logic        presetn,       // Async reset, active low
	input wire logic        psel,          // APB select
	input wire logic        penable,       // APB access phase
	input wire logic        pwrite,        // APB write
	input wire logic [4:0]  paddr,         // APB address
	input wire logic [31:0] pwdata,        // APB write data
	input wire logic [31:0] prdata,        // APB read data
	input wire logic        pready,        // APB ready
	input wire logic        serial_output, // Tx line
	input wire logic        irq_output     // Interrupt
);
	default clocking @(posedge pclk); endclocking
	default disable iff (!presetn);
	logic       done;
	logic       rd_ident;
	logic [7:0] ien_ff;
	logic [7:0] lfc_ff;
	logic       out2_ff;
	// Shadows lag the core by one cycle, so the checks allow for it
	assign done = psel && penable && pready;
	assign rd_ident = done && !pwrite && paddr == 5'h08;
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			ien_ff <= 8'h00;
			lfc_ff <= 8'h00;
			out2_ff <= 1'b0;
		end else if (done && pwrite) begin
			if (paddr == 5'h04 && !lfc_ff[7]) ien_ff <= pwdata[7:0];
			if (paddr == 5'h0c) lfc_ff <= pwdata[7:0];
			if (paddr == 5'h10) out2_ff <= pwdata[3];
		end
	end
	AST_IEN_HI_ZERO: assert property (done && !pwrite && paddr == 5'h04 && !lfc_ff[7]
		|-> prdata[31:4] == 28'h0) else $error("enable register upper bits set");
	AST_NO_EN_NO_IRQ: assert property (ien_ff[3:0] == 4'h0 && $past(ien_ff[3:0]) == 4'h0
		&& $past(ien_ff[3:0], 2) == 4'h0 |-> !irq_output) else $error("irq with no enables");
	AST_PEND_IRQ: assert property (rd_ident && !prdata[0] && prdata[2:1] != 2'b01
		&& out2_ff && $past(out2_ff, 3) |-> ##[0:2] irq_output) else $error("pending, no irq");
	AST_IDENT_CODE: assert property (rd_ident
		|-> prdata[2:0] inside {3'h0, 3'h1, 3'h2, 3'h4, 3'h6}) else $error("bad ident code");
	AST_IDENT_HI_ZERO: assert property (rd_ident |-> prdata[31:3] == 29'h0)
		else $error("ident upper bits set");
	AST_IDENT_NOEN: assert property (rd_ident && ien_ff[3:0] == 4'h0
		|-> prdata[2:0] == 3'h1) else $error("disabled source reported");
	AST_LFC_BACK: assert property (done && !pwrite && paddr == 5'h0c
		|-> prdata[7:0] == lfc_ff) else $error("line format readback wrong");
	AST_BREAK_SPACE: assert property (lfc_ff[6] && $past(lfc_ff[6]) |-> !serial_output)
		else $error("line not spacing in break");
	AST_OUT2_GATE: assert property (!out2_ff && !$past(out2_ff) && !$past(out2_ff, 2)
		|-> !irq_output) else $error("irq with output-2 clear");
	// Main interrupt kinds seen by software
	cover property (rd_ident && prdata[2:0] == 3'h6);
	cover property (rd_ident && prdata[2:0] == 3'h4);
	cover property (rd_ident && prdata[2:0] == 3'h2);
	cover property (rd_ident && prdata[2:0] == 3'h0);
endmodule : uif_checker

// ===== testbench/uif_peer.sv
// Serial peripheral and modem model on the far side of the line
module uif_peer (
	input  wire logic           pclk,         // Bus clock
	output logic                serial_input, // Line towards the receiver
	output uif_pkg::uif_modem_t modem_in_n    // Modem lines, active low
);
	timeunit 1ns;
	timeprecision 100ps;
	localparam int BIT_CLKS = 16; // Divisor one: sixteen ticks a bit
	// Line idles at mark, modem lines inactive
	initial begin
		serial_input = 1'b1;
		modem_in_n = 4'hf;
	end
	// One bit time, entered just after a rising edge
	task put_bit(input logic b);
		serial_input <= b;
		repeat (BIT_CLKS) @(posedge pclk);
	endtask : put_bit
	// A whole character; parity value chosen by the caller, may be wrong
	task send(input logic [7:0] d, input int nb, input logic pe, input logic pv);
		@(posedge pclk);
		put_bit(1'b0);
		for (int i = 0; i < nb; i++) put_bit(d[i]);
		if (pe) put_bit(pv);
		put_bit(1'b1);
	endtask : send
	task modem(input logic [3:0] v);
		@(posedge pclk);
		modem_in_n <= v;
	endtask : modem
endmodule : uif_peer

// ===== testbench/uart_irq_and_line_format_test.sv
// Self-checking bench of the interrupt and line format core
module uart_irq_and_line_format_test;
	timeunit 1ns;
	timeprecision 100ps;
	logic                pclk, presetn, psel, penable, pwrite, pready, pslverr;
	logic [4:0]          paddr;
	logic [31:0]         pwdata, prdata;
	logic                serial_input, serial_output, rts_n, dtr_n, irq_output;
	uif_pkg::uif_modem_t modem_in_n;
	int                  failures, comparisons, nb, gap, t0, t1;
	int                  cyc = 0;
	logic [7:0]          rv, f;
	logic                er;
	logic [15:0]         got, exp;
	// Address, write data, expected read back
	logic [20:0] rows [10] = '{21'h0c3f3f, 21'h0c5a5a, 21'h0c0000, 21'h08ff01,
		21'h04f000, 21'h04f505, 21'h040000, 21'h0c8080, 21'h000101, 21'h0c0303};
	logic [7:0]  fmts [6] = '{8'h03, 8'h1b, 8'h0d, 8'h3b, 8'h2e, 8'h04};
	uif_core i_dut (.pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
		.pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready),
		.pslverr(pslverr), .serial_input(serial_input), .modem_in_n(modem_in_n),
		.serial_output(serial_output), .rts_n(rts_n), .dtr_n(dtr_n), .irq_output(irq_output));
	uif_peer i_peer (.pclk(pclk), .serial_input(serial_input), .modem_in_n(modem_in_n));
	initial begin
		pclk = 1'b0;
		forever #12.5 pclk = ~pclk;
	end
	always @(posedge pclk) cyc <= cyc + 1;
	task results;
		$display("failures=%0d comparisons=%0d", failures, comparisons);
		if (failures == 0 && comparisons > 0) begin
			$display("bench passed");
		end else begin
			$display("bench failed");
		end
		$finish;
	endtask : results
	task chk(input logic [15:0] g, input logic [15:0] e);
		comparisons++;
		if (g !== e) begin
			failures++;
			$display("BAD t=%0t got=%h exp=%h", $time, g, e);
		end
	endtask : chk
	// One APB transfer; answer taken at the rising edge that sees pready high
	task apb(input logic w, input logic [4:0] a, input logic [7:0] d);
		int n;
		@(posedge pclk);
		psel <= 1'b1;
		pwrite <= w;
		paddr <= a;
		pwdata <= {24'h0, d};
		@(posedge pclk);
		penable <= 1'b1;
		n = 0;
		do begin
			@(posedge pclk);
			n++;
		end while (pready !== 1'b1 && n < 50);
		rv = prdata[7:0];
		er = pslverr;
		if (n >= 50) failures++;
		psel <= 1'b0;
		penable <= 1'b0;
	endtask : apb
	task wr(input logic [4:0] a, input logic [7:0] d);
		apb(1'b1, a, d);
	endtask : wr
	task rd(input logic [4:0] a, input logic [7:0] e);
		apb(1'b0, a, 8'h00);
		chk({8'h00, rv}, {8'h00, e});
	endtask : rd
	initial begin
		{presetn, psel, penable, pwrite, paddr, pwdata} = '0;
		failures = 0;
		comparisons = 0;
		repeat (8) @(posedge pclk);
		presetn <= 1'b1;
		foreach (rows[i]) begin
			wr(rows[i][20:16], rows[i][15:8]);
			rd(rows[i][20:16], rows[i][7:0]);
		end
		rd(5'h02, 8'h00);
		chk({15'h0, er}, 16'h1);
		// Frames: two characters back to back, start to start timed
		wr(5'h10, 8'h08);
		wr(5'h04, 8'h02);
		apb(1'b0, 5'h08, 8'h00);
		foreach (fmts[k]) begin
			f = fmts[k];
			nb = f[1:0] + 5;
			exp = 16'hffff;
			for (int i = 0; i < nb; i++) exp[i] = 8'hc5 >> i;
			if (f[3]) exp[nb] = (f[5] ? 1'b0 : ^(8'hc5 & (8'hff >> (8 - nb)))) ^ ~f[4];
			// One idle tick passes before the next start bit
			gap = 16 * (2 + nb + f[3]) + (f[2] ? (nb == 5 ? 8 : 16) : 0) + 1;
			wr(5'h0c, f);
			fork
				begin
					while (serial_output !== 1'b0 && cyc < 19000) @(negedge pclk);
					t0 = cyc;
					repeat (8) @(negedge pclk);
					got = 16'hffff;
					for (int i = 0; i < nb + f[3] + 1; i++) begin
						repeat (16) @(negedge pclk);
						got[i] = serial_output;
					end
					while (serial_output !== 1'b0 && cyc < 19000) @(negedge pclk);
					t1 = cyc;
				end
				begin
					wr(5'h00, 8'hc5);
					repeat (20) @(negedge pclk);
					wr(5'h00, 8'hc5);
				end
			join
			chk(got, exp);
			chk(16'(t1 - t0), 16'(gap));
			repeat (4) @(negedge pclk);
			chk({15'h0, irq_output}, 16'h1);
			rd(5'h08, 8'h02);
			rd(5'h08, 8'h01);
			repeat (220) @(negedge pclk);
		end
		// Break holds the line at space
		wr(5'h0c, 8'h43);
		repeat (20) @(negedge pclk);
		chk({15'h0, serial_output}, 16'h0);
		wr(5'h0c, 8'h03);
		repeat (4) @(negedge pclk);
		chk({15'h0, serial_output}, 16'h1);
		// Received data, then parity error outranking it
		wr(5'h04, 8'h01);
		i_peer.send(8'ha5, 8, 1'b0, 1'b0);
		repeat (40) @(negedge pclk);
		rd(5'h08, 8'h04);
		rd(5'h00, 8'ha5);
		rd(5'h08, 8'h01);
		wr(5'h0c, 8'h1b);
		wr(5'h04, 8'h05);
		i_peer.send(8'h03, 8, 1'b1, 1'b1);
		repeat (40) @(negedge pclk);
		rd(5'h08, 8'h06);
		apb(1'b0, 5'h14, 8'h00);
		rd(5'h08, 8'h04);
		rd(5'h00, 8'h03);
		rd(5'h08, 8'h01);
		// Modem change, gated by output-2
		wr(5'h04, 8'h08);
		i_peer.modem(4'b0111);
		repeat (10) @(negedge pclk);
		rd(5'h08, 8'h00);
		chk({15'h0, irq_output}, 16'h1);
		wr(5'h10, 8'h00);
		repeat (4) @(negedge pclk);
		chk({15'h0, irq_output}, 16'h0);
		apb(1'b0, 5'h18, 8'h00);
		rd(5'h08, 8'h01);
		wr(5'h04, 8'h00);
		i_peer.modem(4'hf);
		repeat (10) @(negedge pclk);
		rd(5'h08, 8'h01);
		// Second reset in mid-break
		wr(5'h0c, 8'h5b);
		presetn <= 1'b0;
		repeat (8) @(posedge pclk);
		presetn <= 1'b1;
		chk({15'h0, serial_output}, 16'h1);
		rd(5'h0c, 8'h00);
		rd(5'h04, 8'h00);
		rd(5'h08, 8'h01);
		results();
	end
	// Watchdog well past the expected run
	initial begin
		repeat (20000) @(posedge pclk);
		failures++;
		results();
	end
endmodule : uart_irq_and_line_format_test
bind uif_core uif_checker i_chk (.pclk(pclk), .presetn(presetn), .psel(psel),
	.penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
	.pready(pready), .serial_output(serial_output), .irq_output(irq_output));
